// file: design/smp_pm_defs.vh
// constants for the sleep-mode power manager
// Summary of operation
// RULE1: after power-on: active mode, lowest performance level, all domains active.
// RULE2: no enable, disable or software reset; always operating.
// RULE3: active mode keeps every clock and power domain running.
// RULE4: sleep entered only on wait-for-interrupt; depth from level select field.
// RULE5: software reads config back before wait-for-interrupt; bridge delay.
// RULE6: set regulator-settled flag once main regulator low-power mode stabilizes.
// RULE7: software checks settled flag before standby or backup entry.
// RULE8: idle wakes on synchronous and asynchronous interrupts.
// RULE9: standby wakes on asynchronous, and synchronous only from run-in-standby sources.
// RULE10: backup left only on backup reset; off only on external reset.
// RULE11: standby entry puts switchable domains in retention on low-power regulator.
// RULE12: standby wake returns three domains to active, restarts main regulator.
// RULE13: core resumes only after third domain active and main regulator ready.
// RULE14: always-on logic wakes from standby without any run-in-standby setting.
// RULE15: distinct level codes; reserved code keeps device active on wait-for-interrupt.
`ifndef SMP_PM_DEFS_VH
`define SMP_PM_DEFS_VH

`define SMP_NSRC 8
// register byte offsets
`define SMP_OFS_SLEEP_CFG 8'h00
`define SMP_OFS_INT_FLAG 8'h04
`define SMP_OFS_INT_MASK 8'h08
`define SMP_OFS_STATE 8'h0c
`define SMP_OFS_RUN_SB 8'h10
// sleep level select codes
`define SMP_LVL_IDLE 3'h2
`define SMP_LVL_STANDBY 3'h4
`define SMP_LVL_BACKUP 3'h5
`define SMP_LVL_OFF 3'h6
// reset values
`define SMP_RST_SLEEP_CFG 3'h2
`define SMP_RST_RUN_SB 8'h00
`define SMP_RST_MASK 2'h0
`define SMP_PERF_LOWEST 2'h0
// interrupt flag positions
`define SMP_FLG_SETTLED 0
`define SMP_FLG_WAKE 1
// axi responses
`define SMP_RESP_OKAY 2'h0
`define SMP_RESP_DECERR 2'h3

`endif

// file: design/smp_rst_sync.v
// reset release synchroniser
`timescale 1ns/10ps
`default_nettype none
module smp_rst_sync
(
    input wire mclk_i,
    input wire rst_b_i,
    output wire rst_b_o
);
    reg meta_r;
    reg sync_r;
    // assert at once, release after two edges
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= 1'b1;
            sync_r <= meta_r;
        end
    end
    assign rst_b_o = sync_r;
endmodule // smp_rst_sync
`default_nettype wire

// file: design/smp_wake_gate.v
// per-source wake qualification for idle and standby
`timescale 1ns/10ps
`default_nettype none
`include "smp_pm_defs.vh"
module smp_wake_gate
(
    input wire [`SMP_NSRC-1:0] sync_irq_i,
    input wire [`SMP_NSRC-1:0] async_irq_i,
    input wire [`SMP_NSRC-1:0] run_sb_i,
    input wire aon_irq_i,
    output wire wake_idle_o,
    output wire wake_sb_o
);
    wire [`SMP_NSRC-1:0] idle_q;
    wire [`SMP_NSRC-1:0] sb_q;
    genvar i;
    generate
        for (i = 0; i < `SMP_NSRC; i = i + 1)
        begin : g_src
            // RULE8: idle takes both kinds
            assign idle_q[i] = sync_irq_i[i] | async_irq_i[i];
            // RULE9: synchronous only if kept running
            assign sb_q[i] = async_irq_i[i] | (sync_irq_i[i] & run_sb_i[i]);
        end
    endgenerate
    // RULE14: always-on source needs no setting
    assign wake_idle_o = (|idle_q) | aon_irq_i;
    assign wake_sb_o = (|sb_q) | aon_irq_i;
endmodule // smp_wake_gate
`default_nettype wire

// file: design/smp_pm_top.v
// sleep-mode power manager with axi4-lite registers
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "smp_pm_defs.vh"
module smp_pm_top
(
    input wire mclk_i,
    input wire rst_b_i,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // core and wake sources
    input wire wfi_i,
    input wire [`SMP_NSRC-1:0] sync_irq_i,
    input wire [`SMP_NSRC-1:0] async_irq_i,
    input wire aon_irq_i,
    input wire backup_rst_det_i,
    input wire ext_rst_i,
    // regulator and domain status
    input wire vreg_lp_stable_i,
    input wire main_vreg_ready_i,
    input wire pd_third_active_i,
    // power and clock controls
    output wire core_run_o,
    output wire clk_run_o,
    output wire [2:0] pd_active_o,
    output wire [2:0] pd_retain_o,
    output wire main_vreg_en_o,
    output wire lp_vreg_sel_o,
    output wire [1:0] perf_level_o,
    output wire [5:0] pm_state_o,
    output wire irq_o
);
    localparam [5:0] ST_ACTIVE = 6'h01;
    localparam [5:0] ST_IDLE = 6'h02;
    localparam [5:0] ST_STANDBY = 6'h04;
    localparam [5:0] ST_WAKE = 6'h08;
    localparam [5:0] ST_BACKUP = 6'h10;
    localparam [5:0] ST_OFF = 6'h20;

    wire rst_b, wake_idle, wake_sb;
    reg [5:0] state_r, state_nxt;
    reg [2:0] sleep_lvl_r, pd_active_r, pd_retain_r;
    reg [`SMP_NSRC-1:0] run_sb_r;
    reg [1:0] int_flag_r, int_flag_nxt, int_mask_r;
    reg stable_d_r, settled_seen_r, main_vreg_en_r, lp_vreg_sel_r;
    // axi state
    reg aw_got_r, w_got_r, bvalid_r, rvalid_r, rd_hit, wr_hit;
    reg [7:0] awaddr_r;
    reg [31:0] wdata_r, rdata_r, rd_mux;
    reg [3:0] wstrb_r;
    reg [1:0] bresp_r, rresp_r;
    wire do_write, do_read, settle_evt, wake_evt;
    wire [1:0] w1c;

    smp_rst_sync u_rst
    (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .rst_b_o(rst_b)
    );

    smp_wake_gate u_wake
    (
        .sync_irq_i(sync_irq_i),
        .async_irq_i(async_irq_i),
        .run_sb_i(run_sb_r),
        .aon_irq_i(aon_irq_i),
        .wake_idle_o(wake_idle),
        .wake_sb_o(wake_sb)
    );

    // address and data may arrive in either order
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign do_write = aw_got_r && w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign do_read = s_axi_arvalid && !rvalid_r;

    always @(posedge mclk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `SMP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? `SMP_RESP_OKAY : `SMP_RESP_DECERR;
            end
            else if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always @*
    begin
        wr_hit = 1'b0;
        if (awaddr_r[7:2] == `SMP_OFS_SLEEP_CFG >> 2)
            wr_hit = 1'b1;
        else if (awaddr_r[7:2] == `SMP_OFS_INT_FLAG >> 2)
            wr_hit = 1'b1;
        else if (awaddr_r[7:2] == `SMP_OFS_INT_MASK >> 2)
            wr_hit = 1'b1;
        else if (awaddr_r[7:2] == `SMP_OFS_STATE >> 2)
            wr_hit = 1'b1;
        else if (awaddr_r[7:2] == `SMP_OFS_RUN_SB >> 2)
            wr_hit = 1'b1;
    end

    always @*
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (s_axi_araddr[7:2] == `SMP_OFS_SLEEP_CFG >> 2)
            rd_mux = {29'h0000_0000, sleep_lvl_r};
        else if (s_axi_araddr[7:2] == `SMP_OFS_INT_FLAG >> 2)
            rd_mux = {30'h0000_0000, int_flag_r};
        else if (s_axi_araddr[7:2] == `SMP_OFS_INT_MASK >> 2)
            rd_mux = {30'h0000_0000, int_mask_r};
        else if (s_axi_araddr[7:2] == `SMP_OFS_STATE >> 2)
            rd_mux = {16'h0000, perf_level_o, pd_retain_r, pd_active_r,
                2'h0, state_r};
        else if (s_axi_araddr[7:2] == `SMP_OFS_RUN_SB >> 2)
            rd_mux = {24'h00_0000, run_sb_r};
        else
            rd_hit = 1'b0;
    end

    always @(posedge mclk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `SMP_RESP_OKAY;
        end
        else if (do_read)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? `SMP_RESP_OKAY : `SMP_RESP_DECERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // RULE2: always operating, no soft reset
    always @(posedge mclk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sleep_lvl_r <= `SMP_RST_SLEEP_CFG;
            int_mask_r <= `SMP_RST_MASK;
            run_sb_r <= `SMP_RST_RUN_SB;
        end
        else if (do_write && wstrb_r[0])
        begin
            if (awaddr_r[7:2] == `SMP_OFS_SLEEP_CFG >> 2)
                sleep_lvl_r <= wdata_r[2:0];
            else if (awaddr_r[7:2] == `SMP_OFS_INT_MASK >> 2)
                int_mask_r <= wdata_r[1:0];
            else if (awaddr_r[7:2] == `SMP_OFS_RUN_SB >> 2)
                run_sb_r <= wdata_r[7:0];
        end
    end

    // RULE6: first rise of stable after power-up
    assign settle_evt = vreg_lp_stable_i && !stable_d_r && !settled_seen_r;
    assign wake_evt = (state_nxt == ST_ACTIVE) && (state_r != ST_ACTIVE);
    assign w1c = (do_write && wstrb_r[0] &&
        awaddr_r[7:2] == `SMP_OFS_INT_FLAG >> 2) ? wdata_r[1:0] : 2'h0;

    // set wins over a same-cycle clear
    always @*
    begin
        int_flag_nxt = int_flag_r & ~w1c;
        if (settle_evt)
            int_flag_nxt[`SMP_FLG_SETTLED] = 1'b1;
        if (wake_evt)
            int_flag_nxt[`SMP_FLG_WAKE] = 1'b1;
    end

    always @(posedge mclk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_flag_r <= 2'h0;
            stable_d_r <= 1'b0;
            settled_seen_r <= 1'b0;
        end
        else
        begin
            int_flag_r <= int_flag_nxt;
            stable_d_r <= vreg_lp_stable_i;
            if (settle_evt)
                settled_seen_r <= 1'b1;
        end
    end

    assign irq_o = |(int_flag_r & int_mask_r);

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_ACTIVE:
                // RULE4: sleep only on wait-for-interrupt
                if (wfi_i)
                begin
                    // RULE15: reserved codes stay active
                    if (sleep_lvl_r == `SMP_LVL_IDLE)
                        state_nxt = ST_IDLE;
                    else if (sleep_lvl_r == `SMP_LVL_STANDBY)
                        state_nxt = ST_STANDBY;
                    else if (sleep_lvl_r == `SMP_LVL_BACKUP)
                        state_nxt = ST_BACKUP;
                    else if (sleep_lvl_r == `SMP_LVL_OFF)
                        state_nxt = ST_OFF;
                end
            ST_IDLE:
                // RULE8: idle wake sources
                if (wake_idle)
                    state_nxt = ST_ACTIVE;
            ST_STANDBY:
                // RULE9: qualified standby wake
                if (wake_sb)
                    state_nxt = ST_WAKE;
            ST_WAKE:
                // RULE13: third domain and main regulator first
                if (pd_third_active_i && main_vreg_ready_i)
                    state_nxt = ST_ACTIVE;
            ST_BACKUP:
                // RULE10: backup reset only
                if (backup_rst_det_i)
                    state_nxt = ST_ACTIVE;
            ST_OFF:
                // RULE10: external reset only
                if (ext_rst_i)
                    state_nxt = ST_ACTIVE;
            default:
                state_nxt = ST_ACTIVE;
        endcase
    end

    // RULE1: power-on state
    always @(posedge mclk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_ACTIVE;
            pd_active_r <= 3'h7;
            pd_retain_r <= 3'h0;
            main_vreg_en_r <= 1'b1;
            lp_vreg_sel_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_nxt == ST_STANDBY)
            begin
                // RULE11: retention on low-power regulator
                pd_active_r <= 3'h0;
                pd_retain_r <= 3'h7;
                main_vreg_en_r <= 1'b0;
                lp_vreg_sel_r <= 1'b1;
            end
            else if (state_nxt == ST_BACKUP || state_nxt == ST_OFF)
            begin
                pd_active_r <= 3'h0;
                pd_retain_r <= 3'h0;
                main_vreg_en_r <= 1'b0;
                lp_vreg_sel_r <= 1'b1;
            end
            else
            begin
                // RULE12: domains active, main regulator restarts
                pd_active_r <= 3'h7;
                pd_retain_r <= 3'h0;
                main_vreg_en_r <= 1'b1;
                // low-power supply holds the core until handover
                lp_vreg_sel_r <= state_nxt == ST_WAKE;
            end
        end
    end

    // RULE13: core held until wake completes
    assign core_run_o = state_r == ST_ACTIVE;
    // RULE3: all clocks run in active mode
    assign clk_run_o = state_r == ST_ACTIVE;
    assign pd_active_o = pd_active_r;
    assign pd_retain_o = pd_retain_r;
    assign main_vreg_en_o = main_vreg_en_r;
    assign lp_vreg_sel_o = lp_vreg_sel_r;
    // RULE1: lowest performance level
    assign perf_level_o = `SMP_PERF_LOWEST;
    assign pm_state_o = state_r;
endmodule // smp_pm_top
`default_nettype wire

// file: design/_unused_placeholder_none.v
// intentionally empty design unit list end
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: bench/smp_far_model.sv
// regulator and third-domain far-side model
`timescale 1ns/10ps
`default_nettype none
module smp_far_model
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic vreg_en_i,
    input wire logic pd3_on_i,
    input wire logic [3:0] dly_i,
    output wire logic stable_o,
    output wire logic vreg_ready_o,
    output wire logic pd3_active_o
);
    logic [3:0] st_r, rg_r, pd_r;
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= 4'h0;
            rg_r <= 4'h0;
            pd_r <= 4'h0;
        end
        else
        begin
            st_r <= st_r + {3'h0, st_r != 4'hf};
            rg_r <= vreg_en_i ? rg_r + {3'h0, rg_r != 4'hf} : 4'h0;
            pd_r <= pd3_on_i ? pd_r + {3'h0, pd_r != 4'hf} : 4'h0;
        end
    end
    assign stable_o = st_r[3];
    assign vreg_ready_o = vreg_en_i && rg_r >= dly_i;
    assign pd3_active_o = pd3_on_i && pd_r >= dly_i;
endmodule // smp_far_model
`default_nettype wire

// file: bench/smp_pm_monitor.sv
// assertion checker for the sleep-mode power manager
`timescale 1ns/10ps
`default_nettype none
module smp_pm_monitor
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic wfi_i,
    input wire logic [7:0] sync_irq_i,
    input wire logic [7:0] async_irq_i,
    input wire logic aon_irq_i,
    input wire logic backup_rst_det_i,
    input wire logic ext_rst_i,
    input wire logic main_vreg_ready_i,
    input wire logic pd_third_active_i,
    input wire logic core_run_o,
    input wire logic clk_run_o,
    input wire logic [2:0] pd_active_o,
    input wire logic [2:0] pd_retain_o,
    input wire logic main_vreg_en_o,
    input wire logic lp_vreg_sel_o,
    input wire logic [1:0] perf_level_o,
    input wire logic [5:0] pm_state_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    perf_lowest_a: assert property (perf_level_o == 2'h0)
        else $error("perf level not lowest");
    active_run_a: assert property (pm_state_o == 6'h01 |->
        core_run_o && clk_run_o && pd_active_o == 3'h7 && main_vreg_en_o &&
        !lp_vreg_sel_o) else $error("active with domain stopped");
    wfi_only_a: assert property
        (pm_state_o == 6'h01 && !wfi_i |=> pm_state_o == 6'h01)
        else $error("sleep without wfi");
    idle_wake_a: assert property
        (pm_state_o == 6'h02 && (|sync_irq_i || |async_irq_i) |=>
        pm_state_o == 6'h01) else $error("idle did not wake");
    sb_async_wake_a: assert property
        (pm_state_o == 6'h04 && (aon_irq_i || |async_irq_i) |=>
        pm_state_o == 6'h08) else $error("standby did not wake");
    sb_retain_a: assert property (pm_state_o == 6'h04 |->
        pd_retain_o == 3'h7 && pd_active_o == 3'h0 && lp_vreg_sel_o &&
        !core_run_o) else $error("standby without retention");
    wake_restore_a: assert property (pm_state_o == 6'h08 |->
        pd_active_o == 3'h7 && pd_retain_o == 3'h0 && main_vreg_en_o &&
        lp_vreg_sel_o) else $error("wake without domains");
    resume_gate_a: assert property
        (pm_state_o == 6'h08 && !(pd_third_active_i && main_vreg_ready_i)
        |=> pm_state_o == 6'h08) else $error("core resumed early");
    backup_hold_a: assert property
        (pm_state_o == 6'h10 && !backup_rst_det_i |=> $stable(pm_state_o))
        else $error("backup left early");
    off_hold_a: assert property
        (pm_state_o == 6'h20 && !ext_rst_i |=> pm_state_o == 6'h20)
        else $error("off left early");
    cover property (pm_state_o == 6'h04 ##1 pm_state_o == 6'h08);
    cover property (pm_state_o == 6'h10 ##1 pm_state_o == 6'h01);
    cover property (pm_state_o == 6'h20 ##1 pm_state_o == 6'h01);
endmodule // smp_pm_monitor
bind smp_pm_top smp_pm_monitor u_mon
(
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .wfi_i(wfi_i),
    .sync_irq_i(sync_irq_i),
    .async_irq_i(async_irq_i),
    .aon_irq_i(aon_irq_i),
    .backup_rst_det_i(backup_rst_det_i),
    .ext_rst_i(ext_rst_i),
    .main_vreg_ready_i(main_vreg_ready_i),
    .pd_third_active_i(pd_third_active_i),
    .core_run_o(core_run_o),
    .clk_run_o(clk_run_o),
    .pd_active_o(pd_active_o),
    .pd_retain_o(pd_retain_o),
    .main_vreg_en_o(main_vreg_en_o),
    .lp_vreg_sel_o(lp_vreg_sel_o),
    .perf_level_o(perf_level_o),
    .pm_state_o(pm_state_o)
);
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the sleep-mode power manager
`timescale 1ns/10ps
`default_nettype none
`include "smp_pm_defs.vh"
module tb_top;
    localparam logic [1:0] ok = `SMP_RESP_OKAY;
    logic mclk_i = 1'b0;
    logic rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, wfi_i, aon_irq_i;
    logic backup_rst_det_i, ext_rst_i, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_run_o;
    logic clk_run_o, main_vreg_en_o, lp_vreg_sel_o, irq_o;
    wire vreg_lp_stable_i, main_vreg_ready_i, pd_third_active_i;
    logic [7:0] s_axi_awaddr, s_axi_araddr, sync_irq_i, async_irq_i;
    logic [31:0] s_axi_wdata, s_axi_rdata, r, rs;
    logic [31:0] seed = 32'h5821c287;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [3:0] dly = 4'h1;
    logic [1:0] s_axi_bresp, s_axi_rresp, perf_level_o;
    logic [2:0] pd_active_o, pd_retain_o;
    logic [2:0] rsv [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    logic [5:0] pm_state_o;
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    int miscompares = 0, checks = 0, k, n;
    smp_pm_top uut (.*);
    smp_far_model u_far
    (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .vreg_en_i(main_vreg_en_o),
        .pd3_on_i(pd_active_o[2]),
        .dly_i(dly),
        .stable_o(vreg_lp_stable_i),
        .vreg_ready_o(main_vreg_ready_i),
        .pd3_active_o(pd_third_active_i)
    );
    always #20 mclk_i = ~mclk_i;
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        bq.push_back(e);
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] e);
        rq.push_back({e, d});
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task automatic go(input logic [2:0] lv);
        axw(`SMP_OFS_SLEEP_CFG, {29'h0, lv}, ok);
        axr(`SMP_OFS_SLEEP_CFG, {29'h0, lv}, ok);
        @(posedge mclk_i);
        wfi_i <= 1'b1;
        @(posedge mclk_i);
        wfi_i <= 1'b0;
        #1;
    endtask
    task automatic kick(input logic [7:0] s, a, input logic [2:0] o);
        @(posedge mclk_i);
        sync_irq_i <= s;
        async_irq_i <= a;
        {aon_irq_i, backup_rst_det_i, ext_rst_i} <= o;
        @(posedge mclk_i);
        {sync_irq_i, async_irq_i} <= 16'h0;
        {aon_irq_i, backup_rst_det_i, ext_rst_i} <= 3'h0;
        #1;
    endtask
    // results seen on the bus are matched in order
    always @(posedge mclk_i)
    begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            chk("bresp", s_axi_bresp, bq.pop_front());
    end
    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        {rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, wfi_i, aon_irq_i} = 4'h0;
        {backup_rst_det_i, ext_rst_i, s_axi_wdata} = 34'h0;
        {s_axi_awaddr, s_axi_araddr, sync_irq_i, async_irq_i} = 32'h0;
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        axr(`SMP_OFS_SLEEP_CFG, 32'h2, ok);
        axr(`SMP_OFS_INT_MASK, 32'h0, ok);
        axr(`SMP_OFS_RUN_SB, 32'h0, ok);
        axr(`SMP_OFS_STATE, 32'h701, ok);
        axr(8'h14, 32'h0, `SMP_RESP_DECERR);
        axw(8'h18, rnd(), `SMP_RESP_DECERR);
        // lane 0 off: write accepted, no effect
        s_axi_wstrb <= 4'he;
        axw(`SMP_OFS_SLEEP_CFG, 32'h4, ok);
        s_axi_wstrb <= 4'hf;
        axr(`SMP_OFS_SLEEP_CFG, 32'h2, ok);
        chk("perf", perf_level_o, 2'h0);
        $display("test reset done");
        axr(`SMP_OFS_INT_FLAG, 32'h1, ok);
        chk("irq", irq_o, 1'b0);
        axw(`SMP_OFS_INT_MASK, 32'h1, ok);
        #1 chk("irq", irq_o, 1'b1);
        axw(`SMP_OFS_INT_FLAG, 32'h1, ok);
        #1 chk("irq", irq_o, 1'b0);
        axw(`SMP_OFS_INT_MASK, 32'h0, ok);
        $display("test flags done");
        foreach (rsv[i])
        begin
            go(rsv[i]);
            chk("rsv", pm_state_o, 6'h01);
        end
        for (k = 0; k < 3; k++)
        begin
            go(`SMP_LVL_IDLE);
            chk("idle", {core_run_o, pm_state_o}, 7'h02);
            r = rnd();
            kick(k == 0 ? r[7:0] | 8'h1 : 8'h0,
                k == 1 ? r[15:8] | 8'h1 : 8'h0, {k == 2, 2'b0});
            chk("idlewake", pm_state_o, 6'h01);
        end
        $display("test idle done");
        rs = (rnd() | 32'h1) & 32'h7f;
        axw(`SMP_OFS_RUN_SB, rs, ok);
        axr(`SMP_OFS_RUN_SB, rs, ok);
        axr(`SMP_OFS_INT_FLAG, 32'h2, ok);
        axw(`SMP_OFS_INT_FLAG, 32'h2, ok);
        for (k = 0; k < 3; k++)
        begin
            dly <= 4'(k * 4 + 1);
            go(`SMP_LVL_STANDBY);
            chk("sb", {pm_state_o, pd_active_o, pd_retain_o, main_vreg_en_o,
                lp_vreg_sel_o}, {6'h04, 3'h0, 3'h7, 2'b01});
            if (k == 0) kick(8'h80, 8'h0, 3'h0);
            chk("sbsync", pm_state_o, 6'h04);
            kick(k == 0 ? 8'h01 : 8'h0, k == 1 ? 8'h10 : 8'h0, {k == 2, 2'b0});
            chk("wake", {pm_state_o, pd_active_o, pd_retain_o,
                main_vreg_en_o, lp_vreg_sel_o},
                {6'h08, 3'h7, 3'h0, 2'b11});
            for (n = 0; n < 40 && pm_state_o !== 6'h01; n++)
                @(posedge mclk_i) #1;
            chk("resume", {pm_state_o, lp_vreg_sel_o, n > dly},
                {6'h01, 2'b01});
        end
        $display("test standby done");
        for (k = 0; k < 2; k++)
        begin
            go(k ? `SMP_LVL_OFF : `SMP_LVL_BACKUP);
            kick(8'hff, 8'hff, k ? 3'h6 : 3'h5);
            chk("deep", pm_state_o, k ? 6'h20 : 6'h10);
            kick(8'h0, 8'h0, k ? 3'h1 : 3'h2);
            chk("deepwake", pm_state_o, 6'h01);
        end
        $display("test deep done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
